// *** aopc_pkg.sv ***
`default_nettype none

package aopc_pkg;

	// ----------------------------------------------------------------
	// Clock, widths and time figures
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ      = 125;
	localparam int unsigned DATA_W       = 12;
	localparam int unsigned RAW_W        = 14;
	localparam int unsigned LATENCY      = 12;
	localparam int unsigned FD_W         = 4;
	localparam int unsigned PD_WAKE_NS   = 2000;
	localparam int unsigned STBY_WAKE_NS = 400;
	localparam int unsigned DCO_RISE_NS  = 32;
	localparam int unsigned PD_WAKE_CYC   = (PD_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned STBY_WAKE_CYC = (STBY_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DCO_RISE_CYC  = (DCO_RISE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WAKE_CNT_W    = 9;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [31:0] OFS_CTRL     = 32'h0000_0000;
	localparam logic [31:0] OFS_STATUS   = 32'h0000_0004;
	localparam logic [31:0] OFS_INT_STAT = 32'h0000_0008;
	localparam logic [31:0] OFS_INT_MASK = 32'h0000_000C;
	localparam logic [31:0] OFS_THRESH   = 32'h0000_0010;
	localparam logic [31:0] OFS_OUT_DIS  = 32'h0000_0014;

	localparam int unsigned CTRL_W           = 10;
	localparam int unsigned CTRL_SPI_MODE    = 0;
	localparam int unsigned CTRL_PWR_DOWN    = 1;
	localparam int unsigned CTRL_STANDBY     = 2;
	localparam int unsigned CTRL_FMT_LSB     = 3;
	localparam int unsigned CTRL_DCS         = 5;
	localparam int unsigned CTRL_OVR_TRAD    = 6;
	localparam int unsigned CTRL_FD_MODE_LSB = 7;
	localparam logic [9:0]  CTRL_RESET       = 10'h000;
	localparam logic [2:0]  THRESH_RESET     = 3'h7;
	localparam logic [1:0]  OUT_DIS_RESET    = 2'h0;

	localparam int unsigned INT_W      = 5;
	localparam int unsigned INT_OR_A   = 0;
	localparam int unsigned INT_OR_B   = 1;
	localparam int unsigned INT_FOR_A  = 2;
	localparam int unsigned INT_FOR_B  = 3;
	localparam int unsigned INT_WAKE   = 4;
	localparam logic [4:0]  INT_RESET  = 5'h00;

	// ----------------------------------------------------------------
	// Codes and encodings
	// ----------------------------------------------------------------
	localparam logic [1:0]  FMT_OFFSET  = 2'h0;
	localparam logic [1:0]  FMT_TWOS    = 2'h1;
	localparam logic [1:0]  FMT_GRAY    = 2'h2;
	localparam logic [2:0]  FD_MAG4     = 3'h0;
	localparam logic [2:0]  FD_MAG3_OVR = 3'h1;
	localparam logic [11:0] CODE_MID    = 12'h800;
	localparam logic [11:0] CODE_POS_FS = 12'h7FF;
	localparam logic [11:0] CODE_NEG_FS = 12'h800;
	localparam logic signed [13:0] RAW_MAX = 14'sh07FF;
	localparam logic signed [13:0] RAW_MIN = 14'sh3800;

	typedef enum logic [1:0] {ST_RUN, ST_PD, ST_STBY, ST_WAKE} aopc_state_t;

endpackage : aopc_pkg

`default_nettype wire

// *** aopc_top.sv ***
// What this block does
// (RULE1) Power-down by register bit or pin; outputs three-stated.
// (RULE2) Pin low ends power-down unless register requests it.
// (RULE3) Power-down stops sampling and output updates.
// (RULE4) Register standby mode wakes faster than power-down.
// (RULE5) Pin mode: format pin picks binary/twos; stabilizer pin.
// (RULE6) Register mode: offset binary, twos or Gray.
// (RULE7) Output-disable pin high three-states data drivers.
// (RULE8) Per-channel register disable three-states data and detect; code clears only o_oe_a/o_oe_b, fast-detect bits stay driven.
// (RULE9) Data leaves twelve sample clocks after sampling.
// (RULE10) Data output clock rises while data is valid.
// (RULE11) Twelve-bit codes with documented full-scale mapping.
// (RULE12) Beyond full scale: clamp code, raise out-of-range.
// (RULE13) Fast over-range high above programmed threshold.
// (RULE14) Traditional mode: over-range from full twelve-bit result.
// (RULE15) Over-range decisions use magnitude, ignoring sign.
// (RULE16) Fast level comes from early coarse bits.
// (RULE17) Four fast-detect bits per channel, mode-selected.
// (RULE18) Outputs off for pin, channel disable or power-down.
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none

module aopc_top (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_sample_clk,
	input  wire logic [13:0] i_sample_a,
	input  wire logic [13:0] i_sample_b,
	input  wire logic        i_power_down_request,
	input  wire logic        i_output_disable_n,
	input  wire logic        i_data_format_select,
	input  wire logic        i_duty_cycle_stabilizer,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic      [31:0] o_hrdata,
	output logic      [11:0] o_data_a,
	output logic      [11:0] o_data_b,
	output logic             o_oe_a,
	output logic             o_oe_b,
	output logic      [3:0]  o_fast_detect_bits_a,
	output logic      [3:0]  o_fast_detect_bits_b,
	output logic             o_out_of_range_a,
	output logic             o_out_of_range_b,
	output logic             o_fast_over_range_a,
	output logic             o_fast_over_range_b,
	output logic             o_data_output_clock,
	output logic             o_duty_cycle_stabilizer_en,
	output logic             o_irq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [11:0] mag_of(input logic [11:0] tc);
		mag_of = tc[11] ? 12'(~tc + 12'h001) : tc;
	endfunction : mag_of

	function automatic logic [3:0] fast_mag(input logic [11:0] tc);
		fast_mag = 4'(mag_of(tc) >> 8);
	endfunction : fast_mag

	function automatic logic [11:0] fmt_code(input logic [11:0] tc, input logic [1:0] f);
		logic [11:0] ob;
		ob = tc ^ aopc_pkg::CODE_MID;
		case (f)
			aopc_pkg::FMT_TWOS: fmt_code = tc;
			aopc_pkg::FMT_GRAY: fmt_code = ob ^ (ob >> 1);
			default:            fmt_code = ob;
		endcase
	endfunction : fmt_code

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// The converter holds each result for a whole sample period, so the
	// data bus is synchronised beside the clock and read only on its edge.
	localparam int unsigned SYNC_W = 33;

	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;
	logic              samp_prev_ff;
	wire  [SYNC_W-1:0] pin_w = {i_sample_clk, i_sample_a, i_sample_b, i_power_down_request,
		i_output_disable_n, i_data_format_select, i_duty_cycle_stabilizer};

	always_ff @(posedge i_clk) begin
		sync1_ff     <= pin_w;
		sync2_ff     <= sync1_ff;
		samp_prev_ff <= sync2_ff[32];
	end

	logic signed [13:0] raw_w [0:1];
	assign raw_w[0] = sync2_ff[31:18];
	assign raw_w[1] = sync2_ff[17:4];
	wire s_pd_pin   = sync2_ff[3];
	wire s_oeb      = sync2_ff[2];
	wire s_dfs      = sync2_ff[1];
	wire s_dcs      = sync2_ff[0];
	wire samp_rise  = sync2_ff[32] & ~samp_prev_ff;

	// ----------------------------------------------------------------
	// Registers and bus slave
	// ----------------------------------------------------------------
	logic [9:0]  ctrl_ff;
	logic [2:0]  thresh_ff;
	logic [1:0]  out_dis_ff;
	logic [4:0]  int_stat_ff;
	logic [4:0]  int_mask_ff;
	logic        wr_pend_ff;
	logic [31:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic        irq_ff;

	wire        bus_acc  = i_hsel & i_htrans[1] & i_hready;
	wire        wr_ctrl  = wr_pend_ff & (wr_addr_ff == aopc_pkg::OFS_CTRL);
	wire        wr_thr   = wr_pend_ff & (wr_addr_ff == aopc_pkg::OFS_THRESH);
	wire        wr_dis   = wr_pend_ff & (wr_addr_ff == aopc_pkg::OFS_OUT_DIS);
	wire        wr_mask  = wr_pend_ff & (wr_addr_ff == aopc_pkg::OFS_INT_MASK);
	wire        wr_istat = wr_pend_ff & (wr_addr_ff == aopc_pkg::OFS_INT_STAT);
	wire [4:0]  int_clr  = wr_istat ? i_hwdata[4:0] : 5'h00;
	wire        spi_mode = ctrl_ff[aopc_pkg::CTRL_SPI_MODE];
	wire        ovr_trad = ctrl_ff[aopc_pkg::CTRL_OVR_TRAD];
	wire [2:0]  fd_mode  = ctrl_ff[aopc_pkg::CTRL_FD_MODE_LSB +: 3];
	wire [1:0]  fmt_sel  = spi_mode ? ctrl_ff[aopc_pkg::CTRL_FMT_LSB +: 2] :
		(s_dfs ? aopc_pkg::FMT_TWOS : aopc_pkg::FMT_OFFSET); // [RULE5] [RULE6]
	wire        nxt_dcs  = spi_mode ? ctrl_ff[aopc_pkg::CTRL_DCS] : s_dcs; // [RULE5]

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	aopc_pkg::aopc_state_t state_ff;
	aopc_pkg::aopc_state_t nxt_state;
	logic [8:0]            wake_cnt_ff;
	logic [8:0]            nxt_wake_cnt;

	wire pd_req    = ctrl_ff[aopc_pkg::CTRL_PWR_DOWN] | s_pd_pin; // [RULE1] [RULE2]
	wire stby_req  = ctrl_ff[aopc_pkg::CTRL_STANDBY]; // [RULE4]
	wire running   = (state_ff == aopc_pkg::ST_RUN);
	wire pd_active = (state_ff == aopc_pkg::ST_PD);
	wire wake_done = (state_ff == aopc_pkg::ST_WAKE) & (wake_cnt_ff == 9'h001) & ~pd_req
		& ~stby_req;

	always_comb begin
		nxt_state    = state_ff;
		nxt_wake_cnt = wake_cnt_ff;
		case (state_ff)
			aopc_pkg::ST_RUN: begin
				if (pd_req) begin
					nxt_state = aopc_pkg::ST_PD;
				end else if (stby_req) begin
					nxt_state = aopc_pkg::ST_STBY;
				end
			end
			aopc_pkg::ST_PD: begin
				// Reference and bias restart from cold, hence the long wait.
				if (!pd_req) begin
					nxt_state    = stby_req ? aopc_pkg::ST_STBY : aopc_pkg::ST_WAKE; // [RULE2]
					nxt_wake_cnt = 9'(aopc_pkg::PD_WAKE_CYC);
				end
			end
			aopc_pkg::ST_STBY: begin
				if (pd_req) begin
					nxt_state = aopc_pkg::ST_PD;
				end else if (!stby_req) begin
					nxt_state    = aopc_pkg::ST_WAKE;
					nxt_wake_cnt = 9'(aopc_pkg::STBY_WAKE_CYC); // [RULE4]
				end
			end
			aopc_pkg::ST_WAKE: begin
				if (pd_req) begin
					nxt_state = aopc_pkg::ST_PD;
				end else if (stby_req) begin
					nxt_state = aopc_pkg::ST_STBY;
				end else if (wake_cnt_ff == 9'h001) begin
					nxt_state = aopc_pkg::ST_RUN;
				end else begin
					nxt_wake_cnt = wake_cnt_ff - 9'h001;
				end
			end
			default: nxt_state = aopc_pkg::ST_PD;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_ff    <= aopc_pkg::ST_WAKE;
			wake_cnt_ff <= 9'(aopc_pkg::STBY_WAKE_CYC);
		end else begin
			state_ff    <= nxt_state;
			wake_cnt_ff <= nxt_wake_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Channel data path
	// ----------------------------------------------------------------
	// The clock is gated off with the sample tick while not running.
	wire tick = samp_rise & running; // [RULE3]

	logic [12:0] pipe_ff [0:1][0:11];
	logic [11:0] data_ff [0:1];
	logic [3:0]  fd_ff   [0:1];
	logic [1:0]  or_ff;
	logic [1:0]  for_ff;
	logic [1:0]  oe_ff;
	logic [11:0] code_w  [0:1];
	logic [3:0]  fmag_w  [0:1];
	logic [3:0]  fd_nxt  [0:1];
	logic [1:0]  oor_w;
	logic [1:0]  hi_w;
	logic [1:0]  fast_w;
	logic [1:0]  nxt_for;
	logic [1:0]  nxt_oe;

	for (genvar g = 0; g < 2; g++) begin : g_ch
		wire ovr = pipe_ff[g][11][12];
		assign hi_w[g]   = raw_w[g] > aopc_pkg::RAW_MAX;
		assign oor_w[g]  = hi_w[g] | (raw_w[g] < aopc_pkg::RAW_MIN); // [RULE12]
		assign code_w[g] = hi_w[g] ? aopc_pkg::CODE_POS_FS :
			(oor_w[g] ? aopc_pkg::CODE_NEG_FS : raw_w[g][11:0]); // [RULE12]
		assign fmag_w[g] = fast_mag(code_w[g]); // [RULE15] [RULE16]
		assign fast_w[g] = fmag_w[g] > {1'b0, thresh_ff}; // [RULE13]
		assign nxt_for[g] = ovr_trad ? ovr : fast_w[g]; // [RULE14]
		assign fd_nxt[g] = (fd_mode == aopc_pkg::FD_MAG4) ? fmag_w[g] :
			(fd_mode == aopc_pkg::FD_MAG3_OVR) ? {fmag_w[g][2:0], ovr} :
			{fmag_w[g][2:1], ovr, fast_w[g]}; // [RULE17]
		assign nxt_oe[g] = ~(s_oeb | out_dis_ff[g] | pd_req); // [RULE7] [RULE8] [RULE18] [RULE1]
	end

	always_ff @(posedge i_clk) begin
		for (int c = 0; c < 2; c++) begin
			// Cleared so that no unknown code reaches the pins or the checks.
			if (i_reset) begin
				pipe_ff[c] <= '{default: 13'h0000};
				data_ff[c] <= 12'h000;
				fd_ff[c]   <= 4'h0;
			end else if (tick) begin
				pipe_ff[c][0] <= {oor_w[c], code_w[c]}; // [RULE9]
				for (int i = 1; i < 12; i++) begin
					pipe_ff[c][i] <= pipe_ff[c][i-1];
				end
				data_ff[c] <= fmt_code(pipe_ff[c][11][11:0], fmt_sel); // [RULE11]
				fd_ff[c]   <= fd_nxt[c];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			or_ff  <= 2'h0;
			for_ff <= 2'h0;
			oe_ff  <= 2'h0;
		end else begin
			or_ff  <= tick ? {pipe_ff[1][11][12], pipe_ff[0][11][12]} : or_ff;
			for_ff <= tick ? nxt_for : for_ff;
			oe_ff  <= nxt_oe;
		end
	end

	// ----------------------------------------------------------------
	// Data output clock
	// ----------------------------------------------------------------
	logic [2:0] dco_cnt_ff;
	logic       dco_ff;
	logic       dcs_ff;
	wire  [2:0] nxt_dco_cnt = tick ? 3'h0 :
		(dco_cnt_ff == 3'(aopc_pkg::DCO_RISE_CYC)) ? dco_cnt_ff : dco_cnt_ff + 3'h1;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			dco_cnt_ff <= 3'h0;
			dco_ff     <= 1'b0;
			dcs_ff     <= 1'b0;
		end else begin
			dco_cnt_ff <= nxt_dco_cnt;
			dco_ff     <= running & ~tick & (nxt_dco_cnt == 3'(aopc_pkg::DCO_RISE_CYC)); // [RULE10]
			dcs_ff     <= nxt_dcs;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts and register writes
	// ----------------------------------------------------------------
	wire [4:0] int_set  = {wake_done, tick & nxt_for[1], tick & nxt_for[0],
		tick & pipe_ff[1][11][12], tick & pipe_ff[0][11][12]};
	// A new event in the clearing cycle stays set.
	wire [4:0] nxt_istat = (int_stat_ff & ~int_clr) | int_set;
	wire [4:0] nxt_mask  = wr_mask ? i_hwdata[4:0] : int_mask_ff;
	wire [31:0] rd_data  =
		(i_haddr == aopc_pkg::OFS_CTRL)     ? {22'h000000, ctrl_ff} :
		(i_haddr == aopc_pkg::OFS_STATUS)   ? {27'h0000000, or_ff, running,
			state_ff == aopc_pkg::ST_STBY, pd_active} :
		(i_haddr == aopc_pkg::OFS_INT_STAT) ? {27'h0000000, int_stat_ff} :
		(i_haddr == aopc_pkg::OFS_INT_MASK) ? {27'h0000000, int_mask_ff} :
		(i_haddr == aopc_pkg::OFS_THRESH)   ? {29'h00000000, thresh_ff} :
		(i_haddr == aopc_pkg::OFS_OUT_DIS)  ? {30'h00000000, out_dis_ff} : 32'h00000000;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ctrl_ff     <= aopc_pkg::CTRL_RESET;
			thresh_ff   <= aopc_pkg::THRESH_RESET;
			out_dis_ff  <= aopc_pkg::OUT_DIS_RESET;
			int_stat_ff <= aopc_pkg::INT_RESET;
			int_mask_ff <= aopc_pkg::INT_RESET;
			wr_pend_ff  <= 1'b0;
			wr_addr_ff  <= 32'h00000000;
			hrdata_ff   <= 32'h00000000;
			irq_ff      <= 1'b0;
		end else begin
			ctrl_ff     <= wr_ctrl ? i_hwdata[9:0] : ctrl_ff;
			thresh_ff   <= wr_thr ? i_hwdata[2:0] : thresh_ff;
			out_dis_ff  <= wr_dis ? i_hwdata[1:0] : out_dis_ff; // [RULE8]
			int_stat_ff <= nxt_istat;
			int_mask_ff <= nxt_mask;
			wr_pend_ff  <= bus_acc & i_hwrite;
			wr_addr_ff  <= bus_acc ? i_haddr : wr_addr_ff;
			hrdata_ff   <= (bus_acc & ~i_hwrite) ? rd_data : 32'h00000000;
			irq_ff      <= |(nxt_istat & nxt_mask);
		end
	end

	assign o_hreadyout                = 1'b1;
	assign o_hresp                    = 1'b0;
	assign o_hrdata                   = hrdata_ff;
	assign o_data_a                   = data_ff[0];
	assign o_data_b                   = data_ff[1];
	assign o_oe_a                     = oe_ff[0];
	assign o_oe_b                     = oe_ff[1];
	assign o_fast_detect_bits_a       = fd_ff[0];
	assign o_fast_detect_bits_b       = fd_ff[1];
	assign o_out_of_range_a           = or_ff[0];
	assign o_out_of_range_b           = or_ff[1];
	assign o_fast_over_range_a        = for_ff[0];
	assign o_fast_over_range_b        = for_ff[1];
	assign o_data_output_clock        = dco_ff;
	assign o_duty_cycle_stabilizer_en = dcs_ff;
	assign o_irq                      = irq_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	a_pd_tristate: assert property (pd_req |=> !o_oe_a && !o_oe_b) // [RULE1] [RULE18]
		else $error("Outputs driven during power-down.");
	a_pd_release: assert property (wake_done |=> running) // [RULE2]
		else $error("Wake did not return to normal operation.");
	a_pd_freeze: assert property (pd_active |=> $stable(o_data_a) && !o_data_output_clock) // [RULE3]
		else $error("Outputs changed while powered down.");
	a_stby_wake: assert property ((state_ff == aopc_pkg::ST_STBY) && !stby_req && !pd_req
		|=> wake_cnt_ff == 9'(aopc_pkg::STBY_WAKE_CYC)) // [RULE4]
		else $error("Standby wake time wrong.");
	a_pin_format: assert property (tick && !spi_mode && !s_dfs
		|=> o_data_a == ($past(pipe_ff[0][11][11:0]) ^ 12'h800)) // [RULE5] [RULE11]
		else $error("Pin-mode offset binary wrong.");
	a_gray_format: assert property (tick && spi_mode && (fmt_sel == aopc_pkg::FMT_GRAY)
		|=> o_data_b == fmt_code($past(pipe_ff[1][11][11:0]), 2'h2)) // [RULE6]
		else $error("Gray code output wrong.");
	a_oeb_pin: assert property (s_oeb |=> !o_oe_a && !o_oe_b) // [RULE7]
		else $error("Output-disable pin ignored.");
	a_chan_disable: assert property (out_dis_ff == 2'h1 && !s_oeb && !pd_req
		|=> !o_oe_a && o_oe_b) // [RULE8]
		else $error("Channel disable not independent.");
	a_pipe_latency: assert property (tick |=> pipe_ff[0][11] == $past(pipe_ff[0][10])
		&& o_out_of_range_a == $past(pipe_ff[0][11][12])) // [RULE9]
		else $error("Pipeline stage skipped.");
	a_dco_rise: assert property (tick ##1 (!tick && running)[*4] |=> o_data_output_clock) // [RULE10]
		else $error("Data output clock did not rise.");
	a_clamp_high: assert property (tick && hi_w[0] |=> pipe_ff[0][0] == 13'h17FF) // [RULE12]
		else $error("Over full scale not clamped.");
	a_fast_thresh: assert property (tick && !ovr_trad
		|=> o_fast_over_range_a == ($past(fmag_w[0]) > {1'b0, $past(thresh_ff)})) // [RULE13] [RULE16]
		else $error("Fast over-range wrong.");
	a_trad_ovr: assert property (tick && ovr_trad |=> o_fast_over_range_b == $past(pipe_ff[1][11][12])) // [RULE14]
		else $error("Traditional over-range wrong.");
	a_sign_ignored: assert property (code_w[0] != 12'h800
		|-> fmag_w[0] == fast_mag(12'(~code_w[0] + 12'h001))) // [RULE15]
		else $error("Magnitude depends on sign.");
	a_fd_mag4: assert property (tick && fd_mode == aopc_pkg::FD_MAG4
		|=> o_fast_detect_bits_b == $past(fmag_w[1])) // [RULE17]
		else $error("Fast-detect bits wrong.");

	c_wake_after_pd: cover property (pd_active ##[1:400] running);
	c_gray_out: cover property (tick && spi_mode && fmt_sel == aopc_pkg::FMT_GRAY);
	c_over_range: cover property (o_out_of_range_a && o_fast_over_range_b);
	c_irq: cover property (o_irq ##1 !o_irq);

endmodule : aopc_top

`default_nettype wire

// *** aopc_capture_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------
// Capture register at the far end of the data pins
// ------------------------------------------------
module aopc_capture_model (
	input  wire logic        i_data_output_clock,
	input  wire logic [11:0] i_data_a,
	input  wire logic [11:0] i_data_b,
	input  wire logic        i_oe_a,
	input  wire logic        i_oe_b,
	output logic      [11:0] o_cap_a,
	output logic      [11:0] o_cap_b
);
	// Released pins have no pull, so they show the inverse of the last level.
	logic [11:0] last_a_ff = 12'h000;
	logic [11:0] last_b_ff = 12'h000;
	wire  [11:0] pin_a     = i_oe_a ? i_data_a : ~last_a_ff;
	wire  [11:0] pin_b     = i_oe_b ? i_data_b : ~last_b_ff;

	always @(posedge i_data_output_clock) begin
		last_a_ff <= pin_a;
		last_b_ff <= pin_b;
		o_cap_a   <= pin_a;
		o_cap_b   <= pin_b;
	end
endmodule : aopc_capture_model

`default_nettype wire

// *** adc_output_power_and_range_control_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module adc_output_power_and_range_control_tb_top;
	// ------------------------------------------------
	// Stimulus, design and far-end capture
	// ------------------------------------------------
	logic        clk      = 1'b0;
	logic        rst      = 1'b1;
	logic        sclk     = 1'b0;
	logic        pdn      = 1'b0;
	logic        oen      = 1'b0;
	logic        data_format_select      = 1'b0;
	logic        duty_cycle_stabilizer      = 1'b0;
	logic        hwrite   = 1'b0;
	logic        trad     = 1'b0;
	logic [1:0]  htrans   = 2'h0;
	logic [13:0] sa       = 14'h0000;
	logic [13:0] sb       = 14'h0000;
	logic [31:0] haddr    = 32'h0000_0000;
	logic [31:0] hwdata   = 32'h0000_0000;
	logic [31:0] rdata;
	logic [11:0] da, db, capa, capb;
	logic [3:0]  fda, fdb;
	logic        rdy, oea, output_disable_n, ora, orb, fora, forb, data_output_clock, dcsen, irq;
	int          n_fail   = 0;
	int          compares = 0;
	int          thr      = 7;

	always #4 clk = ~clk;

	// The sample clock is unrelated in phase to the system clock.
	initial begin
		#3;
		forever #62.5 sclk = ~sclk;
	end

	aopc_top u_dut (.i_clk(clk), .i_reset(rst), .i_sample_clk(sclk), .i_sample_a(sa),
		.i_sample_b(sb), .i_power_down_request(pdn), .i_output_disable_n(oen),
		.i_data_format_select(data_format_select), .i_duty_cycle_stabilizer(duty_cycle_stabilizer), .i_hsel(1'b1),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(),
		.o_hrdata(rdata), .o_data_a(da), .o_data_b(db), .o_oe_a(oea), .o_oe_b(output_disable_n),
		.o_fast_detect_bits_a(fda), .o_fast_detect_bits_b(fdb), .o_out_of_range_a(ora),
		.o_out_of_range_b(orb), .o_fast_over_range_a(fora), .o_fast_over_range_b(forb),
		.o_data_output_clock(data_output_clock), .o_duty_cycle_stabilizer_en(dcsen), .o_irq(irq));

	aopc_capture_model u_cap (.i_data_output_clock(data_output_clock), .i_data_a(da), .i_data_b(db),
		.i_oe_a(oea), .i_oe_b(output_disable_n), .o_cap_a(capa), .o_cap_b(capb));

	task automatic conclude;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done

	// Entered just after a rising edge; holds each phase until ready is seen.
	task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		q = rdata;
		repeat (3) @(posedge clk);
	endtask : ahb

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [31:0] a, m, e, input string n);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		chk(e, q & m, n);
	endtask : rd

	function automatic int clampv(input int v);
		return v > 2047 ? 2047 : (v < -2048 ? -2048 : v);
	endfunction : clampv

	function automatic logic [12:0] expv(input int v, input logic [1:0] f);
		logic [11:0] ob;
		ob = 12'(clampv(v) + 2048);
		if (f == 2'h1)
			ob = ob ^ 12'h800;
		if (f == 2'h2)
			ob = ob ^ (ob >> 1);
		return {(v > 2047 || v < -2048), ob};
	endfunction : expv

	function automatic logic expf(input int v);
		int c;
		c = clampv(v);
		if (trad)
			return v > 2047 || v < -2048;
		return ((c < 0 ? -c : c) >> 8) > thr;
	endfunction : expf

	// Samples change half a sample period before the rise that takes them.
	task automatic dcase(input int va, vb, input logic [1:0] f);
		@(negedge sclk);
		@(posedge clk);
		sa <= 14'(va);
		sb <= 14'(vb);
		repeat (16) @(posedge sclk);
		repeat (10) @(posedge clk);
		chk(expv(va, f), {ora, capa}, "chan a");
		chk(expv(vb, f), {orb, capb}, "chan b");
		chk(expf(va), fora, "fast a");
		chk(expf(vb), forb, "fast b");
	endtask : dcase

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		conclude();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (60) @(posedge clk);
		rd(32'h0, 32'h3FF, 32'h0, "ctrl");
		rd(32'h10, 32'h7, 32'h7, "thresh");
		rd(32'h14, 32'h3, 32'h0, "out dis");
		wr(32'h20, 32'hFFFF_FFFF);
		rd(32'h20, 32'hFFFF_FFFF, 32'h0, "unmapped");
		done("registers");
		dcase(-2048, 2047, 2'h0);
		dcase(0, -1, 2'h0);
		data_format_select <= 1'b1;
		duty_cycle_stabilizer <= 1'b1;
		dcase(-2048, 2047, 2'h1);
		dcase(2100, -2100, 2'h1);
		chk(1'b1, dcsen, "dcs pin");
		done("pin mode");
		for (int f = 0; f < 4; f++) begin
			wr(32'h0, 32'(1 + f * 8));
			dcase(-1000, 1500, 2'(f));
		end
		chk(1'b0, dcsen, "dcs reg");
		thr = 3;
		wr(32'h10, 32'h3);
		dcase(1024, -1024, 2'h0);
		chk(4'h4, fda, "fd bits");
		chk(4'h4, fdb, "fd bits b");
		dcase(767, -767, 2'h0);
		trad = 1'b1;
		wr(32'h0, 32'hC1);
		dcase(2047, -2048, 2'h0);
		dcase(2048, -2049, 2'h0);
		chk(4'hF, fda, "fd mode 1 a");
		chk(4'h1, fdb, "fd mode 1 b");
		done("over-range");
		dcase(100, 100, 2'h0);
		@(negedge sclk);
		@(posedge clk);
		sa <= 14'h00C8;
		repeat (12) @(posedge sclk);
		repeat (10) @(posedge clk);
		chk(12'h864, capa, "old sample");
		@(posedge sclk);
		repeat (10) @(posedge clk);
		chk(12'h8C8, capa, "new sample");
		done("latency");
		oen <= 1'b1;
		repeat (8) @(posedge clk);
		chk(2'h0, {oea, output_disable_n}, "oe pin");
		oen <= 1'b0;
		wr(32'h14, 32'h1);
		repeat (8) @(posedge clk);
		chk(2'h1, {oea, output_disable_n}, "oe reg");
		wr(32'h14, 32'h0);
		done("output disable");
		wr(32'h8, 32'h1F);
		wr(32'hC, 32'h10);
		pdn <= 1'b1;
		repeat (8) @(posedge clk);
		chk(2'h0, {oea, output_disable_n}, "oe pd pin");
		rd(32'h4, 32'h7, 32'h1, "status pd");
		sa <= 14'h0300;
		repeat (16) @(posedge sclk);
		@(posedge clk);
		chk(12'h8C8, da, "frozen");
		chk(1'b0, data_output_clock, "dco pd");
		pdn <= 1'b0;
		repeat (300) @(posedge clk);
		chk(3'h7, {oea, output_disable_n, irq}, "wake");
		wr(32'hC, 32'h0);
		chk(1'b0, irq, "irq masked");
		wr(32'hC, 32'h10);
		chk(1'b1, irq, "irq unmasked");
		wr(32'h8, 32'h10);
		chk(1'b0, irq, "irq clear");
		wr(32'h0, 32'h3);
		pdn <= 1'b1;
		repeat (8) @(posedge clk);
		pdn <= 1'b0;
		repeat (300) @(posedge clk);
		chk(2'h0, {oea, output_disable_n}, "oe pd reg");
		wr(32'h0, 32'h1);
		repeat (300) @(posedge clk);
		wr(32'h0, 32'h5);
		rd(32'h4, 32'h7, 32'h2, "status stby");
		wr(32'h0, 32'h1);
		repeat (60) @(posedge clk);
		rd(32'h4, 32'h7, 32'h4, "stby wake");
		done("power");
		conclude();
	end
endmodule : adc_output_power_and_range_control_tb_top

`default_nettype wire
